// >>> design/pse_pkg.sv
// constants, types and contract list for the pse pin control block
// Contract
// RULE1 - host holds hardware reset low at least 300 us for a full reset
// RULE2 - a hardware reset returns every internal register to its default
// RULE3 - address, self-run and injector straps captured on reset release
// RULE4 - open-drain interrupt pulled low while a fault is flagged
// RULE5 - serial data received on input line only, driven on output line only
// RULE6 - injector strap low selects endpoint mode, high selects midspan mode
// RULE7 - answer slave address 010 plus four address-select pins
// RULE8 - address pins latched after supply lockout ends and after every reset
// RULE9 - low port shutdown input turns that port's power switch off
// RULE10 - self-run strap high at reset starts all ports in automatic mode
// RULE11 - self-run strap low at reset starts all ports in shutdown mode
// RULE12 - software mode writes override the latched self-run strap
// RULE13 - probe sine loss shuts and blocks ports with ac disconnect enabled
// RULE14 - no address acknowledge while any reset cause persists
// RULE15 - strap pin changes outside reset are ignored
// RULE16 - reset, shutdown and strap pins pass two flip-flops before use
package pse_pkg;
    localparam int N_PORTS = 4;
    localparam int RST_MIN_US = 300;
    localparam int CLK_MHZ = 200;
    localparam int RST_MIN_CYC = RST_MIN_US * CLK_MHZ;
    localparam int RST_CNT_W = 17;
    localparam logic [2:0] ADDR_PREFIX = 3'h2;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_INT_STATUS = 8'h08;
    localparam logic [7:0] OFF_INT_CLEAR = 8'h0C;
    localparam logic [7:0] OFF_INT_ENABLE = 8'h10;
    // event bit positions
    localparam int EV_PORT_OFF = 0;
    localparam int EV_SINE_LOSS = 4;
    localparam int EV_ADDR_ACK = 5;
    localparam int EV_W = 6;
    localparam logic [5:0] INT_EN_RST = 6'h00;
    localparam logic [3:0] AC_EN_RST = 4'h0;

    typedef enum logic [1:0] {
        PSE_MODE_SHUTDOWN = 2'b00,
        PSE_MODE_MANUAL = 2'b01,
        PSE_MODE_SEMI = 2'b10,
        PSE_MODE_AUTO = 2'b11
    } pse_mode_t;

    typedef enum logic [1:0] {
        PSE_I2C_IDLE = 2'b00,
        PSE_I2C_ADDR = 2'b01,
        PSE_I2C_ACK = 2'b10,
        PSE_I2C_SKIP = 2'b11
    } pse_i2c_st_t;

    typedef struct packed {
        logic [3:0] addr;
        logic       self_run;
        logic       injector;
    } pse_strap_t;

    typedef struct packed {
        logic       rst_n;
        logic       supply_undervolt_lockout;
        logic       overtemp;
        logic       sine_loss;
        logic [3:0] port_off_n;
        pse_strap_t strap;
        logic       scl;
        logic       sda;
    } pse_pins_t;

    typedef struct packed {
        logic [3:0] ac_en;
        pse_mode_t  [3:0] mode;
    } pse_ctrl_t;

    localparam pse_ctrl_t CTRL_RST = '{ac_en: AC_EN_RST, mode: '{default: PSE_MODE_SHUTDOWN}};
endpackage

// >>> design/pse_pin_control.sv
// pin control logic: reset, straps, port shutdown, interrupt, address acknowledge
`timescale 1ns/1ps
module pse_pin_control #(
    parameter int RST_MIN_CYCLES = pse_pkg::RST_MIN_CYC
) (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // reset causes
    input  wire logic        hw_reset_n_i,
    input  wire logic        supply_undervolt_lockout_i,
    input  wire logic        overtemp_i,
    // straps
    input  wire logic [3:0]  addr_select_pins_i,
    input  wire logic        self_run_mode_i,
    input  wire logic        injector_mode_i,
    // ports
    input  wire logic [3:0]  port_off_n_i,
    input  wire logic        probe_sine_loss_i,
    output logic      [3:0]  port_power_o,
    output logic             injector_mode_o,
    // serial bus
    input  wire logic        bus_clock_i,
    input  wire logic        serial_data_in_line_i,
    output logic             serial_data_out_line_o,
    output logic             serial_data_out_line_oe_o,
    // open-drain interrupt
    output logic             fault_int_n_o,
    output logic             fault_int_n_oe_o
);
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a[7:2] == off[7:2]);
    endfunction

    // pin synchronisers
    pse_pkg::pse_pins_t pin_raw;
    pse_pkg::pse_pins_t meta_q;
    pse_pkg::pse_pins_t pin_q;
    pse_pkg::pse_pins_t prev_q;

    assign pin_raw = '{rst_n: hw_reset_n_i, supply_undervolt_lockout: supply_undervolt_lockout_i, overtemp: overtemp_i,
                       sine_loss: probe_sine_loss_i, port_off_n: port_off_n_i,
                       strap: '{addr: addr_select_pins_i, self_run: self_run_mode_i, injector: injector_mode_i},
                       scl: bus_clock_i, sda: serial_data_in_line_i};

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_q <= '0;
            pin_q  <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= pin_raw; // RULE16
            pin_q  <= meta_q; // RULE16
            // last synchronised levels, for edge detection
            prev_q <= pin_q;
        end
    end

    // reset causes and strap latch
    logic [pse_pkg::RST_CNT_W-1:0] rst_cnt_q, rst_cnt_d;
    logic                          hold_q, hold_d;
    logic                          cause;
    logic                          release_evt;
    pse_pkg::pse_strap_t           strap_q, strap_d;

    always_comb begin
        cause = !pin_q.rst_n || pin_q.supply_undervolt_lockout || pin_q.overtemp;
        rst_cnt_d = rst_cnt_q;
        if (pin_q.rst_n) begin
            rst_cnt_d = '0;
        end else if (rst_cnt_q != pse_pkg::RST_CNT_W'(RST_MIN_CYCLES)) begin
            rst_cnt_d = rst_cnt_q + 1'b1;
        end
        // short reset pulses do not reset the device
        hold_d = 1'b0;
        if (pin_q.supply_undervolt_lockout || pin_q.overtemp) begin
            hold_d = 1'b1; // RULE2
        end else if (!pin_q.rst_n && rst_cnt_q == pse_pkg::RST_CNT_W'(RST_MIN_CYCLES)) begin
            hold_d = 1'b1; // RULE1
        end else if (hold_q && cause) begin
            // stay held until every cause is gone, so straps latch real pin levels
            hold_d = 1'b1; // RULE3
        end
        release_evt = hold_q && !hold_d;
        strap_d = strap_q; // RULE15
        if (release_evt) begin
            strap_d = pin_q.strap; // RULE3 RULE8
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rst_cnt_q <= '0;
            hold_q    <= 1'b1;
            strap_q   <= '0;
        end else begin
            rst_cnt_q <= rst_cnt_d;
            hold_q    <= hold_d;
            strap_q   <= strap_d;
        end
    end

    // serial address acknowledge
    pse_pkg::pse_i2c_st_t i2c_st_q, i2c_st_d;
    logic [7:0]           shift_q, shift_d;
    logic [3:0]           bit_cnt_q, bit_cnt_d;
    logic                 sda_oe_q, sda_oe_d;
    logic                 ack_evt;
    logic                 scl_rise, scl_fall, bus_start, bus_stop;

    always_comb begin
        // edges, start and stop seen on the synchronised bus lines
        scl_rise  = pin_q.scl && !prev_q.scl;
        scl_fall  = !pin_q.scl && prev_q.scl;
        bus_start = pin_q.scl && prev_q.scl && prev_q.sda && !pin_q.sda;
        bus_stop  = pin_q.scl && prev_q.scl && !prev_q.sda && pin_q.sda;
        i2c_st_d  = i2c_st_q;
        shift_d   = shift_q;
        bit_cnt_d = bit_cnt_q;
        sda_oe_d  = sda_oe_q;
        ack_evt   = 1'b0;
        if (cause || hold_q) begin
            i2c_st_d = pse_pkg::PSE_I2C_IDLE; // RULE14
            sda_oe_d = 1'b0;
        end else if (bus_start) begin
            i2c_st_d  = pse_pkg::PSE_I2C_ADDR;
            bit_cnt_d = '0;
            sda_oe_d  = 1'b0;
        end else if (bus_stop) begin
            i2c_st_d = pse_pkg::PSE_I2C_IDLE;
            sda_oe_d = 1'b0;
        end else begin
            case (i2c_st_q)
                pse_pkg::PSE_I2C_ADDR: begin
                    if (scl_rise) begin
                        shift_d   = {shift_q[6:0], pin_q.sda}; // RULE5
                        bit_cnt_d = bit_cnt_q + 1'b1;
                    end else if (scl_fall && bit_cnt_q == 4'h8) begin
                        if (shift_q[7:1] == {pse_pkg::ADDR_PREFIX, strap_q.addr}) begin // RULE7
                            i2c_st_d = pse_pkg::PSE_I2C_ACK;
                            sda_oe_d = 1'b1; // RULE5
                            ack_evt  = 1'b1;
                        end else begin
                            i2c_st_d = pse_pkg::PSE_I2C_SKIP;
                        end
                    end
                end
                pse_pkg::PSE_I2C_ACK: begin
                    if (scl_fall) begin
                        i2c_st_d = pse_pkg::PSE_I2C_SKIP;
                        sda_oe_d = 1'b0;
                    end
                end
                default: begin
                    i2c_st_d = i2c_st_q;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            i2c_st_q  <= pse_pkg::PSE_I2C_IDLE;
            shift_q   <= 8'h00;
            bit_cnt_q <= 4'h0;
            sda_oe_q  <= 1'b0;
        end else begin
            i2c_st_q  <= i2c_st_d;
            shift_q   <= shift_d;
            bit_cnt_q <= bit_cnt_d;
            sda_oe_q  <= sda_oe_d;
        end
    end

    // registers, port power and interrupt
    pse_pkg::pse_ctrl_t        ctrl_q, ctrl_d;
    logic [pse_pkg::EV_W-1:0]  int_st_q, int_st_d;
    logic [pse_pkg::EV_W-1:0]  int_en_q, int_en_d;
    logic [pse_pkg::EV_W-1:0]  events;
    logic [pse_pkg::EV_W-1:0]  int_clr;
    logic [3:0]                power_q, power_d;
    logic                      int_oe_q, int_oe_d;
    logic                      inj_q, inj_d;
    logic [31:0]               prdata_q, prdata_d;
    logic                      pready_q, pready_d;
    logic                      pslverr_q, pslverr_d;
    logic                      access;

    always_comb begin
        access  = psel_i && penable_i;
        int_clr = '0;
        events  = '0;
        events[pse_pkg::EV_PORT_OFF +: 4] = prev_q.port_off_n & ~pin_q.port_off_n;
        events[pse_pkg::EV_SINE_LOSS]     = pin_q.sine_loss && !prev_q.sine_loss;
        events[pse_pkg::EV_ADDR_ACK]      = ack_evt;
        ctrl_d    = ctrl_q;
        int_en_d  = int_en_q;
        prdata_d  = prdata_q;
        pready_d  = 1'b0;
        pslverr_d = pslverr_q;
        // first access edge answers; the edge that sees ready performs the write
        if (access && !pready_q) begin
            pready_d  = 1'b1;
            pslverr_d = 1'b0;
            prdata_d  = 32'h0000_0000;
            if (hit(paddr_i, pse_pkg::OFF_CTRL)) begin
                prdata_d[11:0] = ctrl_q;
            end else if (hit(paddr_i, pse_pkg::OFF_STATUS)) begin
                prdata_d[15:0] = {pin_q.port_off_n, cause, pin_q.sine_loss, strap_q, power_q};
            end else if (hit(paddr_i, pse_pkg::OFF_INT_STATUS)) begin
                prdata_d[pse_pkg::EV_W-1:0] = int_st_q;
            end else if (hit(paddr_i, pse_pkg::OFF_INT_ENABLE)) begin
                prdata_d[pse_pkg::EV_W-1:0] = int_en_q;
            end else if (!hit(paddr_i, pse_pkg::OFF_INT_CLEAR)) begin
                pslverr_d = 1'b1;
            end
        end
        if (access && pready_q && pwrite_i && !pslverr_q) begin
            if (hit(paddr_i, pse_pkg::OFF_CTRL)) begin
                ctrl_d = pwdata_i[11:0]; // RULE12
            end else if (hit(paddr_i, pse_pkg::OFF_INT_ENABLE)) begin
                int_en_d = pwdata_i[pse_pkg::EV_W-1:0];
            end else if (hit(paddr_i, pse_pkg::OFF_INT_CLEAR)) begin
                int_clr = pwdata_i[pse_pkg::EV_W-1:0];
            end
        end
        int_st_d = (int_st_q & ~int_clr) | events;
        if (hold_q) begin
            ctrl_d   = pse_pkg::CTRL_RST; // RULE2
            int_en_d = pse_pkg::INT_EN_RST; // RULE2
            int_st_d = '0; // RULE2
            if (release_evt && pin_q.strap.self_run) begin
                ctrl_d.mode = '{default: pse_pkg::PSE_MODE_AUTO}; // RULE10
            end else if (release_evt) begin
                ctrl_d.mode = '{default: pse_pkg::PSE_MODE_SHUTDOWN}; // RULE11
            end
        end
        for (int i = 0; i < pse_pkg::N_PORTS; i++) begin
            power_d[i] = !hold_q && !cause && ctrl_q.mode[i] != pse_pkg::PSE_MODE_SHUTDOWN
                         && pin_q.port_off_n[i] // RULE9
                         && !(ctrl_q.ac_en[i] && pin_q.sine_loss); // RULE13
        end
        int_oe_d = |(int_st_q & int_en_q); // RULE4
        inj_d    = strap_d.injector; // RULE6
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_q    <= pse_pkg::CTRL_RST;
            int_st_q  <= '0;
            int_en_q  <= pse_pkg::INT_EN_RST;
            power_q   <= 4'h0;
            int_oe_q  <= 1'b0;
            inj_q     <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d;
            int_st_q  <= int_st_d;
            int_en_q  <= int_en_d;
            power_q   <= power_d;
            int_oe_q  <= int_oe_d;
            inj_q     <= inj_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // open-drain pins only ever drive low
    logic low_q;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            low_q <= 1'b0;
        end else begin
            low_q <= 1'b0;
        end
    end

    assign prdata_o                  = prdata_q;
    assign pready_o                  = pready_q;
    assign pslverr_o                 = pslverr_q;
    assign port_power_o              = power_q;
    assign injector_mode_o           = inj_q;
    assign serial_data_out_line_o    = low_q;
    assign serial_data_out_line_oe_o = sda_oe_q;
    assign fault_int_n_o             = low_q;
    assign fault_int_n_oe_o          = int_oe_q;
endmodule

// >>> sim/pse_pin_control_props.sv
// concurrent checks on the pin control block ports
`timescale 1ns/1ps
module pse_pin_control_props #(
    parameter int RST_MIN_CYCLES = pse_pkg::RST_MIN_CYC
) (
    // clock and reset
    input wire logic        core_clk_i,
    input wire logic        reset_i,
    // apb
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // pins
    input wire logic        hw_reset_n_i,
    input wire logic        supply_undervolt_lockout_i,
    input wire logic        overtemp_i,
    input wire logic [3:0]  port_off_n_i,
    input wire logic [3:0]  port_power_o,
    input wire logic        injector_mode_o,
    input wire logic        bus_clock_i,
    input wire logic        serial_data_out_line_o,
    input wire logic        serial_data_out_line_oe_o,
    input wire logic        fault_int_n_o,
    input wire logic        fault_int_n_oe_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_access;
        psel_i && $rose(penable_i);
    endsequence
    sequence s_ack_start;
        $rose(serial_data_out_line_oe_o);
    endsequence
    sequence s_mask_all;
        psel_i && penable_i && pready_o && pwrite_i && paddr_i == 8'h10 && pwdata_i[5:0] == 6'h00;
    endsequence
    a_apb_wait: assert property (s_access |=> pready_o)
        else $error("access not answered after one wait");
    a_pready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    a_err_unmapped: assert property (pready_o |-> pslverr_o == (paddr_i > 8'h13))
        else $error("error flag wrong for address");
    a_int_pin_low: assert property (fault_int_n_oe_o |-> !fault_int_n_o)
        else $error("interrupt driven high");
    a_int_mask: assert property (s_mask_all |-> ##[1:2] !fault_int_n_oe_o)
        else $error("interrupt ignores mask");
    a_sda_low: assert property (serial_data_out_line_oe_o |-> !serial_data_out_line_o)
        else $error("data out driven high");
    a_ack_window: assert property (s_ack_start |-> !bus_clock_i ##[1:30] !serial_data_out_line_oe_o)
        else $error("acknowledge outside clock low phase");
    a_rst_no_ack: assert property (!hw_reset_n_i [*4] |-> !serial_data_out_line_oe_o)
        else $error("acknowledge during reset");
    a_strap_hold: assert property ((hw_reset_n_i && !supply_undervolt_lockout_i && !overtemp_i) [*8]
        |-> $stable(injector_mode_o))
        else $error("strap output moved outside reset");
    for (genvar g = 0; g < 4; g++) begin : g_off
        a_port_off: assert property (!port_off_n_i[g] [*4] |-> !port_power_o[g])
            else $error("port powered while shut");
    end
endmodule
bind pse_pin_control pse_pin_control_props #(.RST_MIN_CYCLES(RST_MIN_CYCLES)) i_props (.*);

// >>> sim/pse_host_model.sv
// serial bus host that addresses the block and looks for its acknowledge
`timescale 1ns/1ps
module pse_host_model (
    // device side
    input  wire logic dev_pull_i,
    output logic      scl_o,
    output logic      sda_line_o
);
    logic host_low = 1'b0;
    initial scl_o = 1'b1;
    // pulled-up line shared by both parties
    assign sda_line_o = !(host_low || dev_pull_i);
    task automatic send_addr(input logic [6:0] a, output logic ack);
        logic [7:0] b;
        b = {a, 1'b0};
        host_low = 1'b1;
        #20 scl_o = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #20 host_low = !b[i];
            #20 scl_o = 1'b1;
            #40 scl_o = 1'b0;
        end
        #20 host_low = 1'b0;
        #20 scl_o = 1'b1;
        #20 ack = !sda_line_o;
        #20 scl_o = 1'b0;
        #20 host_low = 1'b1;
        #20 scl_o = 1'b1;
        #20 host_low = 1'b0;
        // bus free time before the next start
        #40;
    endtask
endmodule

// >>> sim/pse_pin_control_tb_top.sv
// self-checking bench for the pin control block
`timescale 1ns/1ps
module pse_pin_control_tb_top;
    logic        core_clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, ev;
    logic        pready, pslverr, hw_n = 1'b1, supply_undervolt_lockout = 1'b0, self_run = 1'b0, inj = 1'b0, sine = 1'b0;
    logic [3:0]  apins = 4'hF, off_n = 4'hF, pwr_o;
    logic        otemp = 1'b0;
    logic        inj_o, scl, sda, sda_o, sda_oe, int_n, int_oe, ack;
    logic [16:0] lfsr = 17'h15D3B;
    logic [31:0] expq[$];
    int          error_cnt = 0;
    int          checked = 0;
    pse_pin_control #(.RST_MIN_CYCLES(20)) i_dut (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .hw_reset_n_i(hw_n), .supply_undervolt_lockout_i(supply_undervolt_lockout), .overtemp_i(otemp),
        .addr_select_pins_i(apins), .self_run_mode_i(self_run), .injector_mode_i(inj),
        .port_off_n_i(off_n), .probe_sine_loss_i(sine), .port_power_o(pwr_o), .injector_mode_o(inj_o),
        .bus_clock_i(scl), .serial_data_in_line_i(sda), .serial_data_out_line_o(sda_o),
        .serial_data_out_line_oe_o(sda_oe), .fault_int_n_o(int_n), .fault_int_n_oe_o(int_oe));
    pse_host_model i_host (.dev_pull_i(sda_oe & ~sda_o), .scl_o(scl), .sda_line_o(sda));
    initial forever #2.5 core_clk_i = ~core_clk_i;
    function automatic logic [16:0] nxt(input logic [16:0] v);
        return {v[15:0], v[16] ^ v[13]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        pen <= 1'b1;
        do begin
            @(posedge core_clk_i);
        end while (!pready);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    task automatic close_out();
        if (error_cnt == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // read results checked when the answer arrives
    always @(posedge core_clk_i) begin
        if (psel && pen && pready && !pwr) begin
            ev = expq.pop_front();
            chk(prdata, ev);
        end
    end
    initial begin
        #100000;
        error_cnt++;
        close_out();
    end
    initial begin
        lfsr = nxt(lfsr);
        apins <= lfsr[3:0];
        wt(3);
        reset_i <= 1'b0;
        wt(10);
        rd(8'h00, 32'h0);
        rd(8'h04, {16'h0, 4'hF, 2'b00, apins, 6'h00});
        rd(8'h20, 32'h0);
        i_host.send_addr({3'h2, apins}, ack);
        chk(ack, 1'b1);
        i_host.send_addr({3'h2, ~apins}, ack);
        chk(ack, 1'b0);
        wt(1);
        inj <= 1'b1;
        wt(6);
        chk(inj_o, 1'b0);
        bus(1'b1, 8'h00, 32'h155);
        wt(4);
        chk(pwr_o, 4'hF);
        off_n <= 4'hE;
        wt(5);
        chk(pwr_o, 4'hE);
        off_n <= 4'hF;
        bus(1'b1, 8'h10, 32'h3F);
        wt(3);
        chk({int_oe, int_n}, 2'b10);
        bus(1'b1, 8'h0C, 32'h3F);
        wt(3);
        chk(int_oe, 1'b0);
        rd(8'h08, 32'h0);
        sine <= 1'b1;
        wt(5);
        chk(pwr_o, 4'hE);
        rd(8'h08, 32'h10);
        chk(int_oe, 1'b1);
        bus(1'b1, 8'h10, 32'h0);
        wt(3);
        chk(int_oe, 1'b0);
        sine <= 1'b0;
        lfsr = nxt(lfsr);
        apins <= lfsr[3:0];
        self_run <= 1'b1;
        hw_n <= 1'b0;
        wt(1);
        i_host.send_addr({3'h2, apins}, ack);
        chk(ack, 1'b0);
        wt(1);
        hw_n <= 1'b1;
        wt(10);
        rd(8'h00, 32'hFF);
        chk(inj_o, 1'b1);
        chk(pwr_o, 4'hF);
        rd(8'h10, 32'h0);
        i_host.send_addr({3'h2, apins}, ack);
        chk(ack, 1'b1);
        bus(1'b1, 8'h00, 32'h0);
        wt(4);
        chk(pwr_o, 4'h0);
        rd(8'h00, 32'h0);
        lfsr = nxt(lfsr);
        apins <= lfsr[3:0];
        otemp <= 1'b1;
        wt(1);
        i_host.send_addr({3'h2, apins}, ack);
        chk(ack, 1'b0);
        wt(1);
        otemp <= 1'b0;
        supply_undervolt_lockout <= 1'b1;
        wt(4);
        supply_undervolt_lockout <= 1'b0;
        wt(10);
        rd(8'h00, 32'hFF);
        i_host.send_addr({3'h2, apins}, ack);
        chk(ack, 1'b1);
        if (expq.size() != 0) begin
            error_cnt++;
            $display("[FAIL] %0t read answers left unchecked", $time);
        end
        wt(2);
        close_out();
    end
endmodule
